// File: inc/mppio_defines.svh
/*
  register offsets, widths, reset values and mode codes of the port block.
  assumes inclusion by bare name from the package and the design file.
*/
`ifndef MPPIO_DEFINES_SVH
`define MPPIO_DEFINES_SVH
// ****************************************************************
// port widths
// ****************************************************************
`define MPPIO_W1 8
`define MPPIO_W2 8
`define MPPIO_W3 6
`define MPPIO_W4 8
`define MPPIO_WA 4
`define MPPIO_WB 8
`define MPPIO_WC 8
`define MPPIO_WD 8
// ****************************************************************
// register slots: port index times 0x20 plus register offset
// ****************************************************************
`define MPPIO_OFF_DIR 5'h00
`define MPPIO_OFF_OUT 5'h04
`define MPPIO_OFF_PIN 5'h08
`define MPPIO_OFF_PUL 5'h0c
`define MPPIO_OFF_ODC 5'h10
`define MPPIO_OFF_MODE 12'h100
`define MPPIO_PORT_CNT 8
`define MPPIO_IDX_P4 3'h3
`define MPPIO_IDX_PA 3'h4
`define MPPIO_IDX_PD 3'h7
// ****************************************************************
// reset values and modes
// ****************************************************************
`define MPPIO_RST_BYTE 8'h00
`define MPPIO_RST_MODE 3'h7
`define MPPIO_MODE_4 3'h4
`define MPPIO_MODE_5 3'h5
`define MPPIO_MODE_6 3'h6
`define MPPIO_RESP_OK 2'h0
`define MPPIO_RESP_ERR 2'h2
`endif

// File: inc/mppio_pkg.sv
/*
  types of the port block.
  assumes mppio_defines.svh on the include path.
*/
`include "mppio_defines.svh"
package mppio_pkg;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [7:0] mppio_byte_t [`MPPIO_PORT_CNT];
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } mppio_rsp_t;
  typedef enum logic [1:0] {
    MPPIO_W_IDLE = 2'b00,
    MPPIO_W_RESP = 2'b01
  } mppio_wst_t;
endpackage

// File: verilog/mppio_ports.sv
/*
  port block: direction and output latch per two-way port, pin read per port, pull-up on ports a to d,
  open-drain on ports 3 and a, plus address and upper data bus takeover by operating mode.
  assumes an axi4-lite master on core_clk_i and synchronous pin inputs.
*/
// Functional notes
// - each two-way port has a per-pin direction bit: input or output
// - output latch bit is driven on pins set as output, except ports a to c in modes 4 to 6, port d in modes 4 and 5, open-drain highs
// - pin register reads the current levels on the port pins
// - port 4 is eight input-only pins, no direction, read via pin reg
// - ports a to d carry per-pin pull-up enable bits
// - port 3 open-drain bit kills the high drive; port a's does so outside modes 4 to 6
// - mode 6 port a: dir 0 input, dir 1 address out; mode 7 plain
// - mode 6 ports b,c: dir 0 input, dir 1 address out; mode 7 plain
`timescale 1ns/1ps
`include "mppio_defines.svh"
module mppio_ports
  import mppio_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [63:0] pin_i,
  output logic [63:0] pin_o,
  output logic [63:0] pin_oe_o,
  output logic [63:0] pullup_o,
  input wire logic [23:0] addr_bus_i,
  input wire logic [7:0] data_hi_i,
  input wire logic data_hi_oe_i,
  output logic [7:0] data_hi_o
);
  // ****************************************************************
  // register state; port index 0..7 = 1,2,3,4,a,b,c,d
  // ****************************************************************
  mppio_byte_t dir_reg, dir_next;
  mppio_byte_t output_latch_reg, output_latch_next;
  mppio_byte_t pullup_enable_reg, pullup_enable_next;
  mppio_byte_t open_collector_ctrl_reg, open_collector_ctrl_next;
  logic [2:0] mode_reg, mode_next;
  mppio_wst_t wst_reg, wst_next;
  logic [11:0] awa_reg, awa_next;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [31:0] wd_reg, wd_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rv_reg, rv_next;
  mppio_rsp_t rsp_reg, rsp_next;
  logic [7:0] pin_byte [`MPPIO_PORT_CNT];

  function automatic logic [7:0] port_mask(input logic [2:0] idx);
    case (idx)
      3'h2: port_mask = 8'h3f;
      3'h4: port_mask = 8'h0f;
      default: port_mask = 8'hff;
    endcase
  endfunction

  // which registers exist per port; writes elsewhere return slverr
  function automatic logic reg_ok(input logic [11:0] a, input logic wr);
    logic [2:0] p;
    logic [4:0] o;
    p = a[7:5];
    o = a[4:0];
    reg_ok = 1'b0;
    if (a == `MPPIO_OFF_MODE) reg_ok = 1'b1;
    else if (a[11:8] != 4'h0) reg_ok = 1'b0;
    else begin
      case (o)
        `MPPIO_OFF_DIR: reg_ok = (p != `MPPIO_IDX_P4);
        `MPPIO_OFF_OUT: reg_ok = (p != `MPPIO_IDX_P4);
        `MPPIO_OFF_PIN: reg_ok = !wr;
        `MPPIO_OFF_PUL: reg_ok = (p >= `MPPIO_IDX_PA);
        `MPPIO_OFF_ODC: reg_ok = (p == 3'h2) || (p == `MPPIO_IDX_PA);
        default: reg_ok = 1'b0;
      endcase
    end
  endfunction

  // ****************************************************************
  // pin drive
  // ****************************************************************
  logic bus_mode, m6;
  assign bus_mode = (mode_reg == `MPPIO_MODE_4) ||
                    (mode_reg == `MPPIO_MODE_5);
  assign m6 = (mode_reg == `MPPIO_MODE_6);

  always_comb begin
    logic [7:0] val, oe, addr;
    val = 8'h00;
    oe = 8'h00;
    addr = 8'h00;
    pin_o = '0;
    pin_oe_o = '0;
    pullup_o = '0;
    data_hi_o = pin_i[63:56];
    for (int i = 0; i < `MPPIO_PORT_CNT; i++) begin
      val = output_latch_reg[i];
      oe = dir_reg[i];
      addr = 8'h00;
      if (i == 4) addr = {4'h0, addr_bus_i[19:16]};
      if (i == 5) addr = addr_bus_i[15:8];
      if (i == 6) addr = addr_bus_i[7:0];
      if (i >= 4 && i <= 6) begin
        if (bus_mode) begin
          val = addr;
          oe = 8'hff;
        end else if (m6) begin
          val = addr;
        end
      end
      if (i == 7 && bus_mode) begin
        val = data_hi_i;
        oe = {8{data_hi_oe_i}};
      end
      if (i == 3) oe = 8'h00;
      // open drain: drive only the low level, release for high
      if ((i == 2 || i == 4) && !(i == 4 && (bus_mode || m6)))
        oe = oe & ~(open_collector_ctrl_reg[i] & val);
      oe = oe & port_mask(3'(i));
      pin_o[i*8 +: 8] = val & oe;
      pin_oe_o[i*8 +: 8] = oe;
      pullup_o[i*8 +: 8] = pullup_enable_reg[i] & ~oe;
    end
  end

  always_comb begin
    for (int i = 0; i < `MPPIO_PORT_CNT; i++)
      pin_byte[i] = pin_i[i*8 +: 8] & port_mask(3'(i));
  end

  // ****************************************************************
  // axi4-lite slave: one write, one read at a time
  // ****************************************************************
  assign s_axi_awready = (wst_reg == MPPIO_W_IDLE) && !aw_got_reg;
  assign s_axi_wready = (wst_reg == MPPIO_W_IDLE) && !w_got_reg;
  assign s_axi_bvalid = (wst_reg == MPPIO_W_RESP);
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rsp_reg.data;
  assign s_axi_rresp = rsp_reg.resp;

  always_comb begin
    logic [2:0] p;
    logic [7:0] d;
    p = awa_reg[7:5];
    d = wd_reg[7:0] & port_mask(awa_reg[7:5]);
    dir_next = dir_reg;
    output_latch_next = output_latch_reg;
    pullup_enable_next = pullup_enable_reg;
    open_collector_ctrl_next = open_collector_ctrl_reg;
    mode_next = mode_reg;
    wst_next = wst_reg;
    awa_next = awa_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    wd_next = wd_reg;
    bresp_next = bresp_reg;
    case (wst_reg)
      MPPIO_W_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          awa_next = s_axi_awaddr;
          aw_got_next = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          // only the low lane carries data; other lanes ignored
          wd_next = s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
          w_got_next = 1'b1;
        end
        if (aw_got_reg && w_got_reg) begin
          if (!reg_ok(awa_reg, 1'b1)) bresp_next = `MPPIO_RESP_ERR;
          else begin
            bresp_next = `MPPIO_RESP_OK;
            if (awa_reg == `MPPIO_OFF_MODE) mode_next = wd_reg[2:0];
            else begin
              case (awa_reg[4:0])
                `MPPIO_OFF_DIR: dir_next[p] = d;
                `MPPIO_OFF_OUT: output_latch_next[p] = d;
                `MPPIO_OFF_PUL: pullup_enable_next[p] = d;
                `MPPIO_OFF_ODC: open_collector_ctrl_next[p] = d;
                default: bresp_next = `MPPIO_RESP_ERR;
              endcase
            end
          end
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          wst_next = MPPIO_W_RESP;
        end
      end
      MPPIO_W_RESP: if (s_axi_bready) wst_next = MPPIO_W_IDLE;
      default: wst_next = MPPIO_W_IDLE;
    endcase
  end

  always_comb begin
    logic [2:0] p;
    logic [7:0] v;
    p = s_axi_araddr[7:5];
    v = 8'h00;
    rv_next = rv_reg;
    rsp_next = rsp_reg;
    if (rv_reg && s_axi_rready) rv_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rv_next = 1'b1;
      rsp_next.resp = reg_ok(s_axi_araddr, 1'b0) ?
                      `MPPIO_RESP_OK : `MPPIO_RESP_ERR;
      if (s_axi_araddr == `MPPIO_OFF_MODE) v = {5'h00, mode_reg};
      else begin
        case (s_axi_araddr[4:0])
          `MPPIO_OFF_DIR: v = dir_reg[p];
          `MPPIO_OFF_OUT: v = output_latch_reg[p];
          `MPPIO_OFF_PIN: v = pin_byte[p];
          `MPPIO_OFF_PUL: v = pullup_enable_reg[p];
          `MPPIO_OFF_ODC: v = open_collector_ctrl_reg[p];
          default: v = 8'h00;
        endcase
      end
      rsp_next.data = reg_ok(s_axi_araddr, 1'b0) ? {24'h0, v} : 32'h0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `MPPIO_PORT_CNT; i++) begin
        dir_reg[i] <= `MPPIO_RST_BYTE;
        output_latch_reg[i] <= `MPPIO_RST_BYTE;
        pullup_enable_reg[i] <= `MPPIO_RST_BYTE;
        open_collector_ctrl_reg[i] <= `MPPIO_RST_BYTE;
      end
      mode_reg <= `MPPIO_RST_MODE;
      wst_reg <= MPPIO_W_IDLE;
      awa_reg <= 12'h000;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      wd_reg <= 32'h0000_0000;
      bresp_reg <= `MPPIO_RESP_OK;
      rv_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      dir_reg <= dir_next;
      output_latch_reg <= output_latch_next;
      pullup_enable_reg <= pullup_enable_next;
      open_collector_ctrl_reg <= open_collector_ctrl_next;
      mode_reg <= mode_next;
      wst_reg <= wst_next;
      awa_reg <= awa_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      wd_reg <= wd_next;
      bresp_reg <= bresp_next;
      rv_reg <= rv_next;
      rsp_reg <= rsp_next;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_dir_oe;
    !bus_mode && !m6 |-> pin_oe_o[7:0] == dir_reg[0];
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("port 1 oe");
  property p_out_val;
    dir_reg[1] != 8'h00 |->
      (pin_o[15:8] & dir_reg[1]) == (output_latch_reg[1] & dir_reg[1]);
  endproperty
  a_out_val: assert property (p_out_val) else $error("latch out");
  sequence s_pin_req;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h028;
  endsequence
  property p_pin_rd;
    s_pin_req |=> rsp_reg.data[7:0] == $past(pin_i[15:8]);
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin read");
  property p_p4_in;
    pin_oe_o[31:24] == 8'h00;
  endproperty
  a_p4_in: assert property (p_p4_in) else $error("port 4 out");
  property p_pull;
    pullup_o[63:32] == ({pullup_enable_reg[7], pullup_enable_reg[6],
      pullup_enable_reg[5], pullup_enable_reg[4]} & ~pin_oe_o[63:32]);
  endproperty
  a_pull: assert property (p_pull) else $error("pullup");
  property p_od;
    open_collector_ctrl_reg[2][0] && output_latch_reg[2][0] |->
      !pin_oe_o[16] && !pin_o[16];
  endproperty
  a_od: assert property (p_od) else $error("open drain");
  property p_m6;
    m6 && dir_reg[5][4] |-> pin_oe_o[44] && pin_o[44] == addr_bus_i[12];
  endproperty
  a_m6: assert property (p_m6) else $error("mode 6 addr");
  property p_m6a;
    m6 && !dir_reg[4][2] |-> !pin_oe_o[34];
  endproperty
  a_m6a: assert property (p_m6a) else $error("mode 6 a in");
  property p_bus;
    bus_mode |-> pin_oe_o[55:32] == 24'hff_ff_0f;
  endproperty
  a_bus: assert property (p_bus) else $error("bus mode addr");
  property p_rst;
    $rose(rst_n_i) |-> pin_oe_o == 64'h0 || bus_mode;
  endproperty
  a_rst: assert property (@(posedge core_clk_i) p_rst)
    else $error("reset dir");
endmodule // mppio_ports

// File: bench/mppio_board.sv
/*
  board model: level on every port pin from the block's drivers,
  its pull-ups and the bench's own drive.
  assumes the port block's pin outputs on the same clock.
*/
`timescale 1ns/1ps
module mppio_board (
  input wire logic core_clk_i,
  input wire logic [63:0] drv_i,
  input wire logic [63:0] oe_i,
  input wire logic [63:0] pull_i,
  input wire logic [63:0] ext_i,
  input wire logic [63:0] ext_en_i,
  output logic [63:0] lvl_o
);
  // ****************************************************************
  // pin levels
  // ****************************************************************
  logic [63:0] flt_reg = 64'h0;
  logic [63:0] flt_next;
  // floating pins flip every cycle, so no level is read by luck
  always_comb begin
    lvl_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i)
      | (~oe_i & ~ext_en_i & (pull_i | flt_reg));
    flt_next = ~lvl_o;
  end
  always_ff @(posedge core_clk_i) begin
    flt_reg <= flt_next;
  end
endmodule // mppio_board

// File: bench/tb_top.sv
/*
  bench of the port block: axi4-lite master, board model, mode checks.
  assumes mppio_defines.svh on the include path.
*/
`timescale 1ns/1ps
`include "mppio_defines.svh"
module tb_top;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam logic [1:0] ok = `MPPIO_RESP_OK;
  localparam logic [1:0] er = `MPPIO_RESP_ERR;
  localparam logic [4:0] o_dir = `MPPIO_OFF_DIR;
  localparam logic [4:0] o_out = `MPPIO_OFF_OUT;
  localparam logic [4:0] o_pin = `MPPIO_OFF_PIN;
  localparam logic [4:0] o_pul = `MPPIO_OFF_PUL;
  localparam logic [4:0] o_odc = `MPPIO_OFF_ODC;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, data_hi_oe;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [63:0] pin_i, pin_o, pin_oe_o, pullup_o, ext, ext_en;
  logic [23:0] addr_bus;
  logic [7:0] data_hi, data_hi_o;
  int mismatches, num_checks;
  mppio_ports mppio_ports_i (.core_clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .addr_bus_i(addr_bus),
    .data_hi_i(data_hi), .data_hi_oe_i(data_hi_oe),
    .data_hi_o(data_hi_o));
  mppio_board mppio_board_i (.core_clk_i(clk), .drv_i(pin_o),
    .oe_i(pin_oe_o), .pull_i(pullup_o), .ext_i(ext), .ext_en_i(ext_en),
    .lvl_o(pin_i));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [11:0] ad(input int p, input logic [4:0] o);
    return 12'(p * 32) | 12'(o);
  endfunction
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) begin
      mismatches++;
      summarize();
    end
    bready <= 1'b0;
    chk("bresp", e, bresp);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) begin
      mismatches++;
      summarize();
    end
    rready <= 1'b0;
    chk("rresp", e, rresp);
    chk("rdata", d, rdata);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    @(negedge clk);
    chk("oe", 64'h0, pin_oe_o);
    for (int i = 0; i < 8; i++) begin
      if (i != 3) rd(ad(i, o_dir), 8'h00, ok);
    end
    rd(`MPPIO_OFF_MODE, 8'h07, ok);
  endtask
  task automatic t_io();
    ext[15:8] <= 8'h3c;
    wr(ad(1, o_dir), 8'h0f, ok);
    wr(ad(1, o_out), 8'ha5, ok);
    @(negedge clk);
    chk("oe2", 8'h0f, pin_oe_o[15:8]);
    chk("out2", 8'h05, pin_o[15:8]);
    rd(ad(1, o_pin), 8'h35, ok);
    wr(ad(1, o_pin), 8'hff, er);
    rd(ad(1, o_out), 8'ha5, ok);
  endtask
  task automatic t_p4();
    ext[31:24] <= 8'hc3;
    wr(ad(3, o_dir), 8'hff, er);
    rd(ad(3, o_dir), 8'h00, er);
    rd(ad(3, o_pin), 8'hc3, ok);
    chk("oe4", 8'h00, pin_oe_o[31:24]);
  endtask
  task automatic t_pull();
    ext_en[47:40] <= 8'h00;
    wr(ad(5, o_pul), 8'hff, ok);
    wr(ad(5, o_dir), 8'h0f, ok);
    @(negedge clk);
    chk("pull", 8'hf0, pullup_o[47:40]);
    rd(ad(5, o_pin), 8'hf0, ok);
    wr(ad(5, o_pul), 8'h00, ok);
    @(negedge clk);
    chk("pull0", 8'h00, pullup_o[47:40]);
    wr(ad(0, o_pul), 8'hff, er);
    ext_en[47:40] <= 8'hff;
  endtask
  task automatic t_odc();
    wr(ad(2, o_dir), 8'h3f, ok);
    wr(ad(2, o_out), 8'h0f, ok);
    wr(ad(2, o_odc), 8'h03, ok);
    wr(ad(1, o_odc), 8'h03, er);
    wr(ad(4, o_dir), 8'h0f, ok);
    wr(ad(4, o_out), 8'h05, ok);
    wr(ad(4, o_odc), 8'h01, ok);
    @(negedge clk);
    chk("oe3", 8'h3c, pin_oe_o[23:16]);
    chk("out3", 8'h0c, pin_o[23:16]);
    chk("oea", 8'h0e, pin_oe_o[39:32]);
  endtask
  task automatic t_mode();
    @(posedge clk);
    do_reset();
    addr_bus <= 24'h5ac396;
    data_hi <= 8'he7;
    data_hi_oe <= 1'b1;
    ext[63:56] <= 8'h81;
    wr(ad(4, o_dir), 8'h03, ok);
    wr(ad(5, o_dir), 8'hf0, ok);
    wr(ad(6, o_dir), 8'h0f, ok);
    wr(ad(7, o_dir), 8'hff, ok);
    wr(ad(7, o_out), 8'h5a, ok);
    wr(`MPPIO_OFF_MODE, 8'h06, ok);
    @(negedge clk);
    chk("oe6", 32'hff0ff003, pin_oe_o[63:32]);
    chk("out6", 32'h5a06c002, pin_o[63:32]);
    for (int m = 4; m < 6; m++) begin
      wr(`MPPIO_OFF_MODE, 8'(m), ok);
      @(negedge clk);
      chk("oe45", 32'hffffff0f, pin_oe_o[63:32]);
      chk("out45", 32'he796c30a, pin_o[63:32]);
      chk("dhi", 8'he7, data_hi_o);
    end
    @(posedge clk);
    data_hi_oe <= 1'b0;
    @(negedge clk);
    chk("oed", 8'h00, pin_oe_o[63:56]);
    chk("dhin", 8'h81, data_hi_o);
    wr(`MPPIO_OFF_MODE, 8'h07, ok);
    @(negedge clk);
    chk("oe7", 32'hff0ff003, pin_oe_o[63:32]);
    chk("out7", 32'h5a000000, pin_o[63:32]);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, addr_bus, data_hi, data_hi_oe} = 89'h0;
    wstrb = 4'hf;
    ext = 64'h0;
    ext_en = {64{1'b1}};
    mismatches = 0;
    num_checks = 0;
    do_reset();
    t_reset();
    t_io();
    t_p4();
    t_pull();
    t_odc();
    t_mode();
    summarize();
  end
endmodule // tb_top
